// file: verilog/sbs_top.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module sbs_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] bootPaceMode,
  input wire logic ext_request_n,
  output logic bus_release_n,
  input wire logic inbound_valid_n,
  output logic outbound_valid_n,
  input wire logic [63:0] shared_addr_data_bus_i,
  output logic [63:0] shared_addr_data_bus_o,
  output logic shared_addr_data_bus_oe_n,
  input wire logic [8:0] command_id_bus_i,
  output logic [8:0] command_id_bus_o,
  output logic command_id_bus_oe_n,
  input wire logic [7:0] check_bits_bus_i,
  output logic [7:0] check_bits_bus_o,
  output logic check_bits_bus_oe_n,
  output logic command_parity_o,
  output logic command_parity_oe_n
);
  sbs_pkg::sbs_state_t stQ;
  logic aValidQ, aWrQ, wrEn, aPh;
  logic [7:0] aAddrQ;
  logic [31:0] hrdataQ, rdMux, addrQ, extAddrQ, extDataQ;
  logic scModeQ, bootDoneQ, rdPendQ, extWrQ, lineValidQ, lineDirtyQ;
  logic [2:0] paceModeQ;
  logic [1:0] opQ, curOpQ, beatQ;
  logic [3:0] statQ, statSet, statClr;
  logic [63:0] bufQ [4];
  logic [7:0] bufCbQ [4];
  logic [3:0] bufChkQ;
  logic [63:0] swNew;
  logic inV, isData, rdBeat, extData, wrCmd, nullCmd, blkFirst;
  logic errNow, chkNow, parBad, refBad, lastId;
  sbs_pace_if pace ();

  sbs_pacer sbs_pacer_i (.sys_clk(sys_clk), .rstn(rstn), .pace(pace));

  // ********************
  // AHB-Lite slave
  // ********************
  assign aPh = hsel & hready & htrans[1];
  assign wrEn = aValidQ & aWrQ;
  // A read right behind a write would sample the register before the write lands,
  // so that one address phase waits a cycle
  assign hreadyout = !(wrEn && hsel && htrans[1] && !hwrite);
  assign hresp = 1'b0;
  assign hrdata = hrdataQ;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aValidQ <= 1'b0;
      aWrQ <= 1'b0;
      aAddrQ <= 8'h00;
    end else begin
      aValidQ <= aPh;
      if (aPh) begin
        aWrQ <= hwrite;
        aAddrQ <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rdMux = 32'h0;
    case (haddr[7:0])
      sbs_pkg::A_CTRL: rdMux = {31'h0, scModeQ};
      sbs_pkg::A_CMD: rdMux = {30'h0, opQ};
      sbs_pkg::A_ADDR: rdMux = addrQ;
      sbs_pkg::A_STAT: rdMux = {23'h0, stQ, rdPendQ, extWrQ, statQ};
      sbs_pkg::A_LINE: rdMux = {27'h0, paceModeQ, lineDirtyQ, lineValidQ};
      sbs_pkg::A_EXTADDR: rdMux = extAddrQ;
      sbs_pkg::A_EXTDATA: rdMux = extDataQ;
      default: begin
        if (haddr[7:5] == sbs_pkg::A_BUF_HI) begin
          rdMux = haddr[2] ? bufQ[haddr[4:3]][63:32] : bufQ[haddr[4:3]][31:0];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdataQ <= 32'h0;
    end else if (aPh && !hwrite) begin
      hrdataQ <= rdMux;
    end
  end

  // Referencing stored data is where the late parity check happens
  assign refBad = aPh && !hwrite && haddr[7:5] == sbs_pkg::A_BUF_HI
    && bufChkQ[haddr[4:3]]
    && sbs_pkg::sbs_par(bufQ[haddr[4:3]]) != bufCbQ[haddr[4:3]];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scModeQ <= 1'b0;
      addrQ <= 32'h0;
    end else if (wrEn) begin
      if (aAddrQ == sbs_pkg::A_CTRL) scModeQ <= hwdata[0];
      if (aAddrQ == sbs_pkg::A_ADDR) addrQ <= hwdata;
    end
  end

  // A new operation is ignored while one waits to start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opQ <= sbs_pkg::OP_NONE;
    end else if (wrEn && aAddrQ == sbs_pkg::A_CMD && opQ == sbs_pkg::OP_NONE) begin
      opQ <= hwdata[1:0];
    end else if (stQ == sbs_pkg::S_RD_ADDR || stQ == sbs_pkg::S_WR_ADDR) begin
      opQ <= sbs_pkg::OP_NONE;
    end
  end

  // Pace pattern is a strap caught on the first edge after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bootDoneQ <= 1'b0;
      paceModeQ <= sbs_pkg::PACE_RST;
    end else if (!bootDoneQ) begin
      bootDoneQ <= 1'b1;
      paceModeQ <= bootPaceMode;
    end
  end

  // ********************
  // Inbound cycle decode
  // ********************
  assign inV = !inbound_valid_n && stQ == sbs_pkg::S_SLAVE;
  assign isData = command_id_bus_i[sbs_pkg::ID_DATA];
  assign lastId = command_id_bus_i[sbs_pkg::ID_LAST];
  assign wrCmd = inV && !isData && command_id_bus_i[7:5] == sbs_pkg::T_WRITE;
  assign nullCmd = inV && !isData && command_id_bus_i[7:5] == sbs_pkg::T_NULL;
  assign extData = inV && isData && extWrQ;
  // Unsolicited responses are dropped
  assign rdBeat = inV && isData && rdPendQ && !extWrQ
    && command_id_bus_i[sbs_pkg::ID_RESP];
  assign blkFirst = rdBeat && beatQ == 2'h0 && curOpQ == sbs_pkg::OP_BLK_RD;
  assign errNow = command_id_bus_i[sbs_pkg::ID_ERR] && !scModeQ;
  assign chkNow = !command_id_bus_i[sbs_pkg::ID_NOCHK] || scModeQ;
  assign parBad = chkNow
    && sbs_pkg::sbs_par(shared_addr_data_bus_i) != check_bits_bus_i;

  // ********************
  // Interface state
  // ********************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stQ <= sbs_pkg::S_IDLE;
      curOpQ <= sbs_pkg::OP_NONE;
    end else begin
      case (stQ)
        sbs_pkg::S_IDLE: begin
          if (!ext_request_n) begin
            stQ <= sbs_pkg::S_REL;
          end else if (opQ != sbs_pkg::OP_NONE) begin
            curOpQ <= opQ;
            stQ <= (opQ == sbs_pkg::OP_BLK_WR) ? sbs_pkg::S_WR_ADDR : sbs_pkg::S_RD_ADDR;
          end
        end
        sbs_pkg::S_REL: stQ <= sbs_pkg::S_SLAVE;
        sbs_pkg::S_RD_ADDR: stQ <= sbs_pkg::S_SLAVE;
        sbs_pkg::S_WR_ADDR: stQ <= sbs_pkg::S_WR_DATA;
        sbs_pkg::S_WR_DATA: begin
          if (pace.slot && beatQ == sbs_pkg::LAST_BEAT) stQ <= sbs_pkg::S_IDLE;
        end
        sbs_pkg::S_SLAVE: begin
          if (nullCmd || ((extData || rdBeat) && lastId)) begin
            stQ <= sbs_pkg::S_IDLE;
          end
        end
        default: stQ <= sbs_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdPendQ <= 1'b0;
    end else if (stQ == sbs_pkg::S_RD_ADDR) begin
      rdPendQ <= 1'b1;
    end else if (rdBeat && lastId) begin
      rdPendQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      extWrQ <= 1'b0;
      extAddrQ <= 32'h0;
      extDataQ <= 32'h0;
    end else if (wrCmd) begin
      extWrQ <= 1'b1;
      extAddrQ <= shared_addr_data_bus_i[31:0];
    end else if (extData) begin
      extDataQ <= shared_addr_data_bus_i[31:0];
      if (lastId) extWrQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      beatQ <= 2'h0;
    end else if (stQ == sbs_pkg::S_RD_ADDR || stQ == sbs_pkg::S_WR_ADDR) begin
      beatQ <= 2'h0;
    end else if (rdBeat || (stQ == sbs_pkg::S_WR_DATA && pace.slot)) begin
      beatQ <= beatQ + 2'h1;
    end
  end

  // ********************
  // Cache line state and error status
  // ********************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lineValidQ <= 1'b0;
      lineDirtyQ <= 1'b0;
    end else if (blkFirst) begin
      lineValidQ <= !errNow;
      lineDirtyQ <= !errNow;
    end
  end

  always_comb begin
    statSet = 4'h0;
    statSet[sbs_pkg::ST_BUSERR] = blkFirst && errNow;
    statSet[sbs_pkg::ST_PARERR] = blkFirst && !errNow && parBad;
    statSet[sbs_pkg::ST_REFPAR] = refBad;
    statSet[sbs_pkg::ST_EXTWR] = extData && lastId;
    statClr = (wrEn && aAddrQ == sbs_pkg::A_STAT) ? hwdata[3:0] : 4'h0;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      statQ <= 4'h0;
    end else begin
      statQ <= (statQ & ~statClr) | statSet;
    end
  end

  // ********************
  // Doubleword buffer
  // ********************
  assign swNew = aAddrQ[2] ? {hwdata, bufQ[aAddrQ[4:3]][31:0]}
                           : {bufQ[aAddrQ[4:3]][63:32], hwdata};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < 4; k++) begin
        bufQ[k] <= 64'h0;
        bufCbQ[k] <= 8'h00;
      end
      bufChkQ <= 4'h0;
    end else if (rdBeat) begin
      bufQ[beatQ] <= shared_addr_data_bus_i;
      bufCbQ[beatQ] <= check_bits_bus_i;
      bufChkQ[beatQ] <= beatQ != 2'h0 && chkNow;
    end else if (wrEn && aAddrQ[7:5] == sbs_pkg::A_BUF_HI) begin
      bufQ[aAddrQ[4:3]] <= swNew;
      bufCbQ[aAddrQ[4:3]] <= sbs_pkg::sbs_par(swNew);
      bufChkQ[aAddrQ[4:3]] <= 1'b0;
    end
  end

  // ********************
  // Bus pins
  // ********************
  assign pace.start = stQ == sbs_pkg::S_WR_ADDR;
  assign pace.run = stQ == sbs_pkg::S_WR_DATA;
  assign pace.mode = paceModeQ;

  always_comb begin
    bus_release_n = stQ != sbs_pkg::S_REL;
    outbound_valid_n = 1'b1;
    shared_addr_data_bus_o = 64'h0;
    command_id_bus_o = 9'h000;
    check_bits_bus_o = 8'h00;
    case (stQ)
      sbs_pkg::S_RD_ADDR: begin
        outbound_valid_n = 1'b0;
        shared_addr_data_bus_o = {32'h0, addrQ};
        command_id_bus_o = (curOpQ == sbs_pkg::OP_BLK_RD)
          ? {1'b0, sbs_pkg::T_READ, sbs_pkg::ATTR_BLOCK, 1'b0, sbs_pkg::SIZE_8W}
          : {1'b0, sbs_pkg::T_READ, sbs_pkg::ATTR_SINGLE, sbs_pkg::SIZE_WORD};
        check_bits_bus_o = sbs_pkg::sbs_par(shared_addr_data_bus_o);
      end
      sbs_pkg::S_WR_ADDR: begin
        outbound_valid_n = 1'b0;
        shared_addr_data_bus_o = {32'h0, addrQ};
        command_id_bus_o = {1'b0, sbs_pkg::T_WRITE, sbs_pkg::ATTR_BLOCK, 1'b0,
                            sbs_pkg::SIZE_8W};
        check_bits_bus_o = sbs_pkg::sbs_par(shared_addr_data_bus_o);
      end
      sbs_pkg::S_WR_DATA: begin
        outbound_valid_n = !pace.slot;
        shared_addr_data_bus_o = bufQ[beatQ];
        command_id_bus_o = {1'b1, beatQ == sbs_pkg::LAST_BEAT, 7'h00};
        check_bits_bus_o = bufCbQ[beatQ];
      end
      default: outbound_valid_n = 1'b1;
    endcase
  end

  // Pins float everywhere except in our own address cycles and the whole block-write data state, gap cycles included
  assign shared_addr_data_bus_oe_n = !(stQ == sbs_pkg::S_RD_ADDR
    || stQ == sbs_pkg::S_WR_ADDR || stQ == sbs_pkg::S_WR_DATA);
  assign command_id_bus_oe_n = shared_addr_data_bus_oe_n;
  assign check_bits_bus_oe_n = shared_addr_data_bus_oe_n;
  assign command_parity_oe_n = shared_addr_data_bus_oe_n;
  assign command_parity_o = ^command_id_bus_o;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_REL_ONE: assert property (!bus_release_n |=> bus_release_n && stQ == sbs_pkg::S_SLAVE)
    else $error("release not one cycle");
  AST_REL_CAUSE: assert property ($fell(bus_release_n) |-> !$past(ext_request_n))
    else $error("release without request");
  AST_UNCOMP: assert property (stQ == sbs_pkg::S_RD_ADDR |-> !outbound_valid_n ##1
    (stQ == sbs_pkg::S_SLAVE && rdPendQ && shared_addr_data_bus_oe_n))
    else $error("no slave state after read");
  AST_FLOAT: assert property (stQ == sbs_pkg::S_SLAVE |-> shared_addr_data_bus_oe_n
    && command_id_bus_oe_n) else $error("driving in slave state");
  AST_EXTWR_END: assert property (extData && lastId |=> stQ == sbs_pkg::S_IDLE
    && statQ[sbs_pkg::ST_EXTWR] && !extWrQ) else $error("write did not end");
  AST_DIRTY: assert property (blkFirst && !errNow |=> lineDirtyQ && lineValidQ)
    else $error("line not dirty exclusive");
  AST_BUSERR: assert property (blkFirst && errNow |=> !lineValidQ
    && statQ[sbs_pkg::ST_BUSERR]) else $error("bus error missed");
  AST_PARERR: assert property (blkFirst && !errNow && parBad |=> lineValidQ
    && statQ[sbs_pkg::ST_PARERR]) else $error("parity error missed");
  AST_LATER_IGN: assert property (rdBeat && beatQ != 2'h0 && !statQ[sbs_pkg::ST_BUSERR]
    |=> !statQ[sbs_pkg::ST_BUSERR]) else $error("late error honoured");
  AST_ACCEPT: assert property (stQ == sbs_pkg::S_SLAVE && inbound_valid_n |=> $stable(beatQ))
    else $error("beat taken without valid");
  AST_BLKWR: assert property ($rose(stQ == sbs_pkg::S_WR_ADDR) |->
    ##[5:11] stQ == sbs_pkg::S_IDLE) else $error("block write pacing wrong");
  AST_ID_TOP: assert property (!outbound_valid_n |->
    command_id_bus_o[8] == (stQ == sbs_pkg::S_WR_DATA)) else $error("identifier top bit");

  COV_EXTWR: cover property (wrCmd ##[1:8] extData && lastId);
  COV_BLKRD: cover property (blkFirst ##[1:20] rdBeat && lastId);
  COV_BLKWR: cover property (stQ == sbs_pkg::S_WR_DATA && pace.slot && beatQ == 2'h3);
  COV_BUSERR: cover property (blkFirst && errNow);
endmodule

// file: pkg/sbs_pkg.sv
package sbs_pkg;
  // ********************
  // Register map (byte addresses)
  // ********************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_ADDR = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_LINE = 8'h10;
  localparam logic [7:0] A_EXTADDR = 8'h14;
  localparam logic [7:0] A_EXTDATA = 8'h18;
  localparam logic [2:0] A_BUF_HI = 3'h1;
  // ********************
  // Identifier and command fields
  // ********************
  localparam int ID_DATA = 8;
  localparam int ID_LAST = 7;
  localparam int ID_RESP = 6;
  localparam int ID_ERR = 5;
  localparam int ID_NOCHK = 4;
  localparam logic [2:0] T_READ = 3'h0;
  localparam logic [2:0] T_WRITE = 3'h2;
  localparam logic [2:0] T_NULL = 3'h3;
  localparam logic [1:0] ATTR_BLOCK = 2'h2;
  localparam logic [1:0] ATTR_SINGLE = 2'h3;
  localparam logic [1:0] SIZE_8W = 2'h1;
  localparam logic [2:0] SIZE_WORD = 3'h3;
  // ********************
  // Software operations, status bits, reset values
  // ********************
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WORD_RD = 2'h1;
  localparam logic [1:0] OP_BLK_RD = 2'h2;
  localparam logic [1:0] OP_BLK_WR = 2'h3;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam int ST_BUSERR = 0;
  localparam int ST_PARERR = 1;
  localparam int ST_REFPAR = 2;
  localparam int ST_EXTWR = 3;
  localparam logic [2:0] PACE_RST = 3'h0;
  // ********************
  // Pace patterns: bit i set means cycle i of the period carries data
  // ********************
  localparam logic [7:0] PAT_MASK [8] = '{8'h01, 8'h03, 8'h03, 8'h01,
                                          8'h03, 8'h03, 8'h01, 8'h03};
  localparam logic [2:0] PAT_LAST [8] = '{3'h0, 3'h2, 3'h3, 3'h1,
                                          3'h4, 3'h5, 3'h2, 3'h7};

  typedef enum logic [2:0] {S_IDLE, S_REL, S_RD_ADDR, S_WR_ADDR, S_WR_DATA,
                            S_SLAVE} sbs_state_t;

  // Even parity per byte of a doubleword
  function automatic logic [7:0] sbs_par(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction
endpackage

// file: pkg/sbs_pace_if.sv
`timescale 1ns/1ps
interface sbs_pace_if;
  logic start;
  logic run;
  logic [2:0] mode;
  logic slot;
  modport core (output start, output run, output mode, input slot);
  modport pacer (input start, input run, input mode, output slot);
endinterface

// file: verilog/sbs_pacer.sv
`timescale 1ns/1ps
module sbs_pacer (
  input wire logic sys_clk,
  input wire logic rstn,
  sbs_pace_if.pacer pace
);
  logic [2:0] posQ;

  // ********************
  // Pattern walker
  // ********************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      posQ <= 3'h0;
    end else if (pace.start) begin
      posQ <= 3'h0;
    end else if (pace.run) begin
      posQ <= (posQ == sbs_pkg::PAT_LAST[pace.mode]) ? 3'h0 : posQ + 3'h1;
    end
  end

  assign pace.slot = pace.run & sbs_pkg::PAT_MASK[pace.mode][posQ];

  AST_PACE_GAP: assert property (@(posedge sys_clk) disable iff (!rstn)
    (pace.run && pace.mode == 3'h7 && posQ == 3'h2) |-> !pace.slot [*6])
    else $error("pace gap broken");
endmodule

// file: test/sbs_agent.sv
`timescale 1ns/1ps
// ********************
// Far-side agent: arbitration, external write, read response
// ********************
module sbs_agent (
  input wire logic sys_clk,
  input wire logic bus_release_n,
  input wire logic outbound_valid_n,
  input wire logic devOeN,
  input wire logic [63:0] sadOut,
  input wire logic [8:0] cmdOut,
  input wire logic [7:0] chkOut,
  output logic ext_request_n,
  output logic inbound_valid_n,
  output logic [63:0] sadWire,
  output logic [8:0] cmdWire,
  output logic [7:0] chkWire
);
  localparam logic [8:0] WR_CMD = {1'b0, sbs_pkg::T_WRITE, sbs_pkg::ATTR_SINGLE,
                                   sbs_pkg::SIZE_WORD};
  logic drv;
  logic [63:0] sadA;
  logic [8:0] cmdA;
  logic [7:0] chkA;
  logic [80:0] floatQ;
  initial begin
    ext_request_n = 1'b1;
    inbound_valid_n = 1'b1;
    drv = 1'b0;
    floatQ = '0;
  end
  // Released lines flip every cycle so a stale value never passes for data
  always @(posedge sys_clk) begin
    floatQ <= ~{sadWire, cmdWire, chkWire};
  end
  assign sadWire = !devOeN ? sadOut : drv ? sadA : floatQ[80:17];
  assign cmdWire = !devOeN ? cmdOut : drv ? cmdA : floatQ[16:8];
  assign chkWire = !devOeN ? chkOut : drv ? chkA : floatQ[7:0];
  function automatic logic [7:0] par8(input logic [63:0] d);
    logic [7:0] p;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction
  task automatic put(input logic [63:0] d, input logic [8:0] id, input logic bad);
    @(posedge sys_clk);
    drv <= 1'b1;
    sadA <= d;
    cmdA <= id;
    chkA <= par8(d) ^ {8{bad}};
    inbound_valid_n <= 1'b0;
  endtask
  task automatic idle_cycle(input logic float);
    @(posedge sys_clk);
    inbound_valid_n <= 1'b1;
    drv <= !float;
  endtask
  task automatic wait_for(input logic rd);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((rd ? !(outbound_valid_n === 1'b0 && cmdOut[8] === 1'b0) :
                bus_release_n !== 1'b0) && n < 100);
    if (n >= 100) begin
      sysbus_slave_side_transfers_test.hang();
    end
  endtask
  task automatic arb();
    @(posedge sys_clk);
    ext_request_n <= 1'b0;
    wait_for(1'b0);
    // Drop the request and keep off the bus two cycles past the release
    @(posedge sys_clk);
    ext_request_n <= 1'b1;
  endtask
  task automatic ext_null();
    arb();
    put(64'h0, {1'b0, sbs_pkg::T_NULL, 5'h1f}, 1'b0);
    idle_cycle(1'b1);
  endtask
  task automatic ext_write(input logic [63:0] a, input logic [63:0] d);
    arb();
    put(a, WR_CMD, 1'b0);
    put(d, 9'h18f, 1'b0);
    idle_cycle(1'b1);
  endtask
  task automatic read_resp(input logic [255:0] d, input int beats, input logic [3:0] errM,
                           input logic [3:0] badM, input logic noChk, input int gap);
    wait_for(1'b1);
    for (int i = 0; i < beats; i++) begin
      put(d[64*i +: 64], {1'b1, i == beats - 1, 1'b1, errM[i], noChk, 4'hf},
          badM[i]);
      for (int g = 0; g < gap && i < beats - 1; g++) begin
        idle_cycle(1'b0);
      end
    end
    idle_cycle(1'b1);
  endtask
endmodule

// file: test/sysbus_slave_side_transfers_test.sv
`timescale 1ns/1ps
// ********************
// Register-driven bench against the far-side agent
// ********************
module sysbus_slave_side_transfers_test;
  logic sys_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, bootPaceMode;
  logic ext_request_n, bus_release_n, inbound_valid_n, outbound_valid_n;
  logic [63:0] sadI, sadO, lastAdr;
  logic [8:0] cmdI, cmdO, lastCmd;
  logic [7:0] chkI, chkO;
  logic sadOeN, cmdOeN, chkOeN, parO, parOeN;
  int errors, checked, cyc;
  int beatT[$];
  logic [63:0] beatD[$];
  logic [8:0] beatId[$];
  logic [7:0] beatC[$];
  logic lastPar;
  logic [2:0] lastOe;
  localparam logic [31:0] ALL = 32'hffffffff;
  // Offsets of beats 1..3 from beat 0, one hex digit each
  localparam logic [11:0] PACE [8] = '{12'h123, 12'h134, 12'h145, 12'h246,
                                       12'h156, 12'h167, 12'h369, 12'h189};
  // Digits: error mask, bad parity mask, {0,noChk,scMode,lineValid}, status
  localparam logic [15:0] CASES [6] = '{16'h0010, 16'h1001, 16'h0112, 16'he410,
                                        16'h0150, 16'h1172};
  assign hready = hreadyout;
  sbs_top sbs_top_i (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bootPaceMode(bootPaceMode),
    .ext_request_n(ext_request_n), .bus_release_n(bus_release_n),
    .inbound_valid_n(inbound_valid_n), .outbound_valid_n(outbound_valid_n),
    .shared_addr_data_bus_i(sadI), .shared_addr_data_bus_o(sadO),
    .shared_addr_data_bus_oe_n(sadOeN), .command_id_bus_i(cmdI), .command_id_bus_o(cmdO),
    .command_id_bus_oe_n(cmdOeN), .check_bits_bus_i(chkI), .check_bits_bus_o(chkO),
    .check_bits_bus_oe_n(chkOeN), .command_parity_o(parO), .command_parity_oe_n(parOeN));
  sbs_agent sbs_agent_i (.sys_clk(sys_clk), .bus_release_n(bus_release_n),
    .outbound_valid_n(outbound_valid_n), .devOeN(sadOeN), .sadOut(sadO), .cmdOut(cmdO),
    .chkOut(chkO), .ext_request_n(ext_request_n), .inbound_valid_n(inbound_valid_n),
    .sadWire(sadI), .cmdWire(cmdI), .chkWire(chkI));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Device cycles are judged on the resolved wire, so a wrong enable shows up
  always @(posedge sys_clk) begin
    cyc++;
    if (rstn === 1'b1 && outbound_valid_n === 1'b0) begin
      if (cmdI[8] === 1'b1) begin
        beatT.push_back(cyc);
        beatD.push_back(sadI);
        beatId.push_back(cmdI);
        beatC.push_back(chkI);
      end else begin
        lastCmd = cmdI;
        lastAdr = sadI;
        lastPar = parO;
        lastOe = {cmdOeN, chkOeN, parOeN};
      end
    end
  end
  task automatic stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("[FAIL] wait expected answer seen timeout");
    stop_test();
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) begin
      hang();
    end
    r = hrdata;
    chk("hresp", 64'h0, 64'(hresp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input string nm);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, 64'(e), 64'(r & m));
  endtask
  task automatic dorst(input logic [2:0] m, input int c);
    @(posedge sys_clk);
    bootPaceMode <= m;
    rstn <= 1'b0;
    repeat (c) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  initial begin
    logic [255:0] d;
    logic [15:0] c;
    logic [31:0] b;
    int n;
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    bootPaceMode = 3'h0;
    errors = 0;
    checked = 0;
    cyc = 0;
    dorst(3'h0, 12);
    rdchk(sbs_pkg::A_STAT, 32'h0, 32'h1ff, "stat rst");
    rdchk(8'h40, 32'h0, ALL, "unmapped");
    sbs_agent_i.ext_write(64'h5_1234_5670, 64'hffff_0000_cafe_0001);
    rdchk(sbs_pkg::A_STAT, 32'h8, 32'h1ff, "ext done");
    rdchk(sbs_pkg::A_EXTADDR, 32'h1234_5670, ALL, "ext addr");
    rdchk(sbs_pkg::A_EXTDATA, 32'hcafe_0001, ALL, "ext data");
    wr(sbs_pkg::A_STAT, 32'hf);
    sbs_agent_i.ext_null();
    rdchk(sbs_pkg::A_STAT, 32'h0, 32'h1ff, "null idle");
    d = {192'h0, 64'h1111_2222_3333_4444};
    wr(sbs_pkg::A_ADDR, 32'h2004);
    fork
      wr(sbs_pkg::A_CMD, 32'(sbs_pkg::OP_WORD_RD));
      sbs_agent_i.read_resp(d, 1, 4'h0, 4'h0, 1'b0, 0);
    join
    chk("word cmd", 64'h01b, 64'(lastCmd));
    chk("word adr", 64'h2004, 64'(lastAdr[31:0]));
    rdchk(8'h20, 32'h3333_4444, ALL, "word data");
    for (int k = 0; k < 6; k++) begin
      c = CASES[k];
      d = {64'hd3, 64'hd2, 64'hd1, 64'hd0} + 256'(k);
      wr(sbs_pkg::A_CTRL, {31'h0, c[5]});
      wr(sbs_pkg::A_ADDR, 32'h1000);
      fork
        wr(sbs_pkg::A_CMD, 32'(sbs_pkg::OP_BLK_RD));
        sbs_agent_i.read_resp(d, 4, c[15:12], c[11:8], c[6], k % 3);
      join
      chk("blk cmd", 64'h011, 64'(lastCmd));
      rdchk(sbs_pkg::A_STAT, 32'(c[2:0]), 32'h1ff, "blk stat");
      rdchk(sbs_pkg::A_LINE, c[4] ? 32'h3 : 32'h0, c[4] ? 32'h3 : 32'h1, "line");
      for (int i = 0; i < 8 && k == 0; i++) begin
        rdchk(8'h20 + 8'(4 * i), d[32*i +: 32], ALL, "buffer");
      end
      if (k == 3) begin
        rdchk(8'h30, d[128 +: 32], ALL, "ref data");
        rdchk(sbs_pkg::A_STAT, 32'h4, 32'hf, "ref par");
      end
      wr(sbs_pkg::A_STAT, 32'hf);
    end
    wr(sbs_pkg::A_CTRL, 32'h0);
    for (int m = 0; m < 8; m++) begin
      dorst(3'(m), 2);
      rdchk(sbs_pkg::A_LINE, 32'(m) << 2, 32'h1c, "pace mode");
      b = 32'h0b00_0000 + 32'(16 * m);
      for (int i = 0; i < 8; i++) begin
        wr(8'h20 + 8'(4 * i), b + 32'(i));
      end
      wr(sbs_pkg::A_ADDR, 32'h3000);
      beatT.delete();
      beatD.delete();
      beatId.delete();
      beatC.delete();
      wr(sbs_pkg::A_CMD, 32'(sbs_pkg::OP_BLK_WR));
      n = 0;
      while (beatT.size() < 4 && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
      if (n >= 100) begin
        hang();
      end
      chk("pace", 64'(PACE[m]), 64'({4'(beatT[1] - beatT[0]), 4'(beatT[2] - beatT[0]),
          4'(beatT[3] - beatT[0])}));
      chk("wr cmd", 64'h051, 64'(lastCmd));
      chk("wr par", 64'(^9'h051), 64'(lastPar));
      chk("wr oe", 64'h0, 64'(lastOe));
      for (int i = 0; i < 4; i++) begin
        chk("wr data", {b + 32'(2 * i + 1), b + 32'(2 * i)}, beatD[i]);
        chk("wr id", i == 3 ? 64'h3 : 64'h2, 64'(beatId[i][8:7]));
        chk("wr chk", 64'(sbs_agent_i.par8({b + 32'(2 * i + 1), b + 32'(2 * i)})),
            64'(beatC[i]));
      end
    end
    stop_test();
  end
endmodule
